// ### mpi_mac_pins.v
// mii pin interface of the ethernet controller: tx, rx, status and management
`timescale 1ns/1ps
`default_nettype none
`include "mpi_mac_pins_map.vh"
// Operation
// - tx enable rises in the same tx clock period as the first preamble nibble on the data lines.
// - after the last nibble, tx enable drops before the next rising tx clock edge.
// - in mii mode the four tx data lines carry one nibble per tx clock, meaningful only with tx enable.
// - in 10 Mbps mode data goes out serially on tx data bit 0 alone while tx enable is high.
// - all tx outputs are launched relative to the phy-supplied tx clock.
// - rx data valid, rx data and rx error are sampled on the phy-supplied rx clock.
// - in mii mode an rx nibble is accepted only on rx clock cycles with data valid high.
// - in 10 Mbps mode serial rx data comes from rx data bit 0 alone, qualified by data valid.
// - rx error with data valid marks the frame errored; rx error without data valid is ignored.
// - tx error with tx enable makes the phy send illegal symbols; it has no effect at 10 Mbps or without enable.
// - carrier sense high means the medium is busy.
// - the management clock is driven out and management data moves in step with it.
// - after reset the management data pin is undriven until a transfer needs to drive it.
module mpi_mac_pins
(
   input wire ref_clk,
   input wire rst_n,
   input wire serialMode,
   input wire fullDuplex,
   input wire txValid,
   input wire [3:0] txData,
   input wire txLast,
   input wire txErr,
   output wire txReady,
   output wire rxValid,
   output wire [3:0] rxData,
   output wire rxFrameEnd,
   output wire rxFrameErr,
   output wire collisionSeen,
   output wire mediumBusy,
   input wire mgmtStart,
   input wire mgmtWrite,
   input wire [4:0] mgmtPhyAddr,
   input wire [4:0] mgmtRegAddr,
   input wire [15:0] mgmtWrData,
   output wire mgmtBusy,
   output wire mgmtDone,
   output wire [15:0] mgmtRdData,
   input wire tx_clock_in,
   output wire tx_enable_out,
   output wire tx_data_bit0,
   output wire [2:0] tx_data_upper,
   output wire tx_error_out,
   input wire collision_in,
   input wire rx_clock_in,
   input wire rx_data_valid_in,
   input wire rx_data_bit0,
   input wire [2:0] rx_data_upper,
   input wire rx_error_in,
   input wire carrier_sense_in,
   output wire mgmt_clock_out,
   input wire mgmt_data_in,
   output wire mgmt_data_out,
   output wire mgmt_data_oe
);
   localparam [31:0] MDC_HALF = `MPI_MDC_HALF_CYC;
   localparam ST_IDLE = 1'b0, ST_RUN = 1'b1;
   // every pin input passes two flops before any logic sees it
   wire [10:0] pinIn = {tx_clock_in, rx_clock_in, rx_data_valid_in, rx_error_in, rx_data_upper,
      rx_data_bit0, collision_in, carrier_sense_in, mgmt_data_in};
   wire [10:0] pinSync;
   genvar gi;
   generate
      for (gi = 0; gi < 11; gi = gi + 1)
      begin : g_sync
         reg meta_ff, stable_ff;
         always @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_ff <= 1'b0;
               stable_ff <= 1'b0;
            end
            else
            begin
               meta_ff <= pinIn[gi];
               stable_ff <= meta_ff;
            end
         end
         assign pinSync[gi] = stable_ff;
      end
   endgenerate
   wire txClkS = pinSync[10];
   wire rxClkS = pinSync[9];
   wire rxDvS = pinSync[8];
   wire rxErS = pinSync[7];
   wire [3:0] rxNibS = pinSync[6:3];
   wire colS = pinSync[2];
   wire crsS = pinSync[1];
   wire mdiS = pinSync[0];

   reg txClkD_ff, rxClkD_ff;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txClkD_ff <= 1'b0;
         rxClkD_ff <= 1'b0;
      end
      else
      begin
         txClkD_ff <= txClkS;
         rxClkD_ff <= rxClkS;
      end
   end
   // launch on the falling edge so the phy sees stable data at its rising edge
   wire txFall = txClkD_ff & ~txClkS;
   wire rxRise = ~rxClkD_ff & rxClkS;

   // transmit path
   reg txEn_ff, txLast_ff, txD0_ff, txEr_ff;
   reg [3:0] txNib_ff;
   reg [1:0] txBit_ff;
   reg [2:0] txUp_ff;
   wire txMidNib = serialMode & (txBit_ff != `MPI_SER_LAST);
   wire txLoadPt = txFall & (~txEn_ff | (~txMidNib & ~txLast_ff));
   assign txReady = txLoadPt;
   wire txLoad = txLoadPt & txValid;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txEn_ff <= 1'b0;
         txNib_ff <= 4'h0;
         txLast_ff <= 1'b0;
         txBit_ff <= 2'h0;
         txD0_ff <= 1'b0;
         txUp_ff <= 3'h0;
         txEr_ff <= 1'b0;
      end
      else if (txFall)
      begin
         if (txLoad)
         begin
            // first nibble and enable go out on the same edge
            txEn_ff <= 1'b1;
            txNib_ff <= txData;
            txLast_ff <= txLast;
            txBit_ff <= 2'h0;
            txD0_ff <= txData[0];
            txUp_ff <= serialMode ? 3'h0 : txData[3:1];
            txEr_ff <= txErr & ~serialMode;
         end
         else if (txEn_ff & txMidNib)
         begin
            txBit_ff <= txBit_ff + 2'h1;
            txD0_ff <= txNib_ff[txBit_ff + 2'h1];
         end
         else
         begin
            // dropped at the fall after the last nibble, ahead of the next rise
            txEn_ff <= 1'b0;
            txD0_ff <= 1'b0;
            txUp_ff <= 3'h0;
            txEr_ff <= 1'b0;
            txLast_ff <= 1'b0;
         end
      end
   end
   assign tx_enable_out = txEn_ff;
   assign tx_data_bit0 = txD0_ff;
   assign tx_data_upper = txUp_ff;
   assign tx_error_out = txEr_ff;

   // receive path
   reg rxIn_ff, rxErrAcc_ff, rxValid_ff, rxEnd_ff, rxErrOut_ff;
   reg [3:0] rxSh_ff, rxData_ff;
   reg [1:0] rxBit_ff;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxIn_ff <= 1'b0;
         rxErrAcc_ff <= 1'b0;
         rxSh_ff <= 4'h0;
         rxBit_ff <= 2'h0;
         rxValid_ff <= 1'b0;
         rxData_ff <= 4'h0;
         rxEnd_ff <= 1'b0;
         rxErrOut_ff <= 1'b0;
      end
      else
      begin
         rxValid_ff <= 1'b0;
         rxEnd_ff <= 1'b0;
         if (rxRise)
         begin
            if (rxDvS)
            begin
               rxIn_ff <= 1'b1;
               // error only counts alongside data valid; a new frame starts clean
               rxErrAcc_ff <= (rxIn_ff & rxErrAcc_ff) | rxErS;
               if (serialMode)
               begin
                  rxSh_ff <= {rxNibS[0], rxSh_ff[3:1]};
                  rxBit_ff <= rxIn_ff ? rxBit_ff + 2'h1 : 2'h1;
                  if (rxIn_ff & (rxBit_ff == `MPI_SER_LAST))
                  begin
                     rxValid_ff <= 1'b1;
                     rxData_ff <= {rxNibS[0], rxSh_ff[3:1]};
                  end
               end
               else
               begin
                  rxValid_ff <= 1'b1;
                  rxData_ff <= rxNibS;
               end
            end
            else if (rxIn_ff)
            begin
               // valid dropped: frame over, leftover serial bits are discarded
               rxIn_ff <= 1'b0;
               rxEnd_ff <= 1'b1;
               rxErrOut_ff <= rxErrAcc_ff;
               rxErrAcc_ff <= 1'b0;
               rxBit_ff <= 2'h0;
            end
         end
      end
   end
   assign rxValid = rxValid_ff;
   assign rxData = rxData_ff;
   assign rxFrameEnd = rxEnd_ff;
   assign rxFrameErr = rxErrOut_ff;

   // medium status, already synchronised
   reg col_ff, crs_ff;
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         col_ff <= 1'b0;
         crs_ff <= 1'b0;
      end
      else
      begin
         col_ff <= colS & ~fullDuplex;
         crs_ff <= crsS;
      end
   end
   assign collisionSeen = col_ff;
   assign mediumBusy = crs_ff;

   // management transfer: data changes on clock fall, phy samples on rise
   reg mState_ff, mClk_ff, mRead_ff, mOut_ff, mOe_ff, mDone_ff;
   reg [4:0] mDiv_ff;
   reg [6:0] mBit_ff;
   reg [63:0] mSh_ff;
   reg [15:0] mRd_ff;
   wire mTick = (mDiv_ff == (MDC_HALF[4:0] - 5'h1));
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mState_ff <= ST_IDLE;
         mDiv_ff <= 5'h0;
         mClk_ff <= 1'b0;
         mBit_ff <= 7'h0;
         mSh_ff <= 64'h0;
         mRead_ff <= 1'b0;
         mOut_ff <= 1'b0;
         mOe_ff <= 1'b0;
         mRd_ff <= 16'h0;
         mDone_ff <= 1'b0;
      end
      else
      begin
         mDone_ff <= 1'b0;
         case (mState_ff)
            ST_IDLE:
            begin
               mClk_ff <= 1'b0;
               mDiv_ff <= 5'h0;
               mOe_ff <= 1'b0;
               if (mgmtStart)
               begin
                  mState_ff <= ST_RUN;
                  mRead_ff <= ~mgmtWrite;
                  mOut_ff <= 1'b1;
                  mOe_ff <= 1'b1;
                  mBit_ff <= 7'h1;
                  mSh_ff <= {`MPI_MGMT_PREAMBLE, `MPI_MGMT_SOF,
                     mgmtWrite ? `MPI_MGMT_OP_WR : `MPI_MGMT_OP_RD, mgmtPhyAddr, mgmtRegAddr,
                     mgmtWrite ? `MPI_MGMT_TA_WR : `MPI_MGMT_TA_RD, mgmtWrite ? mgmtWrData : 16'h0} << 1;
               end
            end
            ST_RUN:
            begin
               mDiv_ff <= mTick ? 5'h0 : mDiv_ff + 5'h1;
               if (mTick)
               begin
                  mClk_ff <= ~mClk_ff;
                  if (mClk_ff)
                  begin
                     // sample at the fall that closes each read data bit
                     if (mRead_ff & (mBit_ff >= `MPI_MGMT_RD_FIRST))
                        mRd_ff <= {mRd_ff[14:0], mdiS};
                     if (mBit_ff == `MPI_MGMT_BITS)
                     begin
                        mState_ff <= ST_IDLE;
                        mOe_ff <= 1'b0;
                        mOut_ff <= 1'b0;
                        mDone_ff <= 1'b1;
                     end
                     else
                     begin
                        mOut_ff <= mSh_ff[63];
                        mSh_ff <= {mSh_ff[62:0], 1'b0};
                        mBit_ff <= mBit_ff + 7'h1;
                        // release the pin from turnaround on for a read
                        mOe_ff <= ~(mRead_ff & (mBit_ff >= `MPI_MGMT_TA_BIT));
                     end
                  end
               end
            end
            default:
               mState_ff <= ST_IDLE;
         endcase
      end
   end
   assign mgmt_clock_out = mClk_ff;
   assign mgmt_data_out = mOut_ff;
   assign mgmt_data_oe = mOe_ff;
   assign mgmtBusy = mState_ff;
   assign mgmtDone = mDone_ff;
   assign mgmtRdData = mRd_ff;
endmodule // mpi_mac_pins
`default_nettype wire

// ### mpi_mac_pins_map.vh
// constants for the mii pin interface block
`ifndef MPI_MAC_PINS_MAP_VH
`define MPI_MAC_PINS_MAP_VH
`define MPI_CLK_PERIOD_NS 10
`define MPI_MDC_HALF_NS 200
`define MPI_MDC_HALF_CYC ((`MPI_MDC_HALF_NS + `MPI_CLK_PERIOD_NS - 1) / `MPI_CLK_PERIOD_NS)
`define MPI_MGMT_BITS 7'h40
`define MPI_MGMT_TA_BIT 7'h2e
`define MPI_MGMT_RD_FIRST 7'h31
`define MPI_MGMT_PREAMBLE 32'hffffffff
`define MPI_MGMT_SOF 2'h1
`define MPI_MGMT_OP_WR 2'h1
`define MPI_MGMT_OP_RD 2'h2
`define MPI_MGMT_TA_WR 2'h2
`define MPI_MGMT_TA_RD 2'h0
`define MPI_SER_LAST 2'h3
`endif

// ### mpi_mac_pins_properties.sv
// port assertions for the mii pin interface
`timescale 1ns/1ps
`default_nettype none
module mpi_mac_pins_properties
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic serialMode,
   input wire logic fullDuplex,
   input wire logic txValid,
   input wire logic [3:0] txData,
   input wire logic txReady,
   input wire logic rxFrameEnd,
   input wire logic rxFrameErr,
   input wire logic collisionSeen,
   input wire logic mediumBusy,
   input wire logic mgmtBusy,
   input wire logic mgmtDone,
   input wire logic tx_enable_out,
   input wire logic tx_data_bit0,
   input wire logic [2:0] tx_data_upper,
   input wire logic tx_error_out,
   input wire logic carrier_sense_in,
   input wire logic mgmt_clock_out,
   input wire logic mgmt_data_oe
);
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!rst_n);
sequence takeNib;
   !serialMode && txReady && txValid;
endsequence
sequence busyHeld;
   carrier_sense_in [*4];
endsequence
AST_TX_START: assert property (takeNib |=> tx_enable_out && {tx_data_upper, tx_data_bit0} == $past(txData))
   else $error("taken nibble not on the pins");
AST_TX_END: assert property ($fell(tx_enable_out) |-> !tx_data_bit0 && tx_data_upper == 3'h0 && !tx_error_out)
   else $error("pins not cleared with enable");
AST_TX_ERR: assert property (tx_error_out |-> tx_enable_out && !serialMode)
   else $error("tx error outside enable");
AST_SERIAL: assert property (serialMode |-> tx_data_upper == 3'h0)
   else $error("upper bits driven in serial mode");
AST_RX_ERR: assert property (!rxFrameEnd |-> $stable(rxFrameErr))
   else $error("frame error moved without frame end");
AST_COL: assert property (fullDuplex && $past(fullDuplex) |-> !collisionSeen)
   else $error("collision seen in full duplex");
AST_CRS: assert property (busyHeld |-> mediumBusy)
   else $error("carrier not reported busy");
AST_MDIO_IDLE: assert property (!mgmtBusy |-> !mgmt_data_oe && !mgmt_clock_out)
   else $error("management pins active when idle");
AST_MDC_HALF: assert property ($rose(mgmt_clock_out) |=> mgmt_clock_out [*8])
   else $error("management clock high phase short");
AST_MGMT_DONE: assert property ($fell(mgmtBusy) |-> mgmtDone)
   else $error("busy fell without done");
endmodule // mpi_mac_pins_properties
bind mpi_mac_pins mpi_mac_pins_properties chk (.*);
`default_nettype wire

// ### mpi_phy_model.sv
// phy model: free mii clocks, tx capture, rx driver, management responder
`timescale 1ns/1ps
`default_nettype none
module mpi_phy_model
(
   output logic txClk,
   output logic rxClk,
   input wire logic txEn,
   input wire logic [3:0] txNib,
   input wire logic txEr,
   output logic rxDv,
   output logic [3:0] rxNib,
   output logic rxEr,
   input wire logic mdc,
   input wire logic mdo,
   input wire logic mdoe,
   output wire logic mdi,
   input wire logic [15:0] rdVal
);
logic [4:0] txQ[$];
logic [63:0] mFrame = 64'h0;
logic [6:0] bitNo = 7'h0;
logic rd = 1'h0;
logic phyOe = 1'h0;
logic phyBit = 1'h1;
initial
begin
   txClk = 1'h0;
   rxClk = 1'h0;
   rxDv = 1'h0;
   rxNib = 4'h5;
   rxEr = 1'h0;
end
// mii clocks run free; rx phase unrelated to tx
always #80 txClk = ~txClk;
initial #37 forever #80 rxClk = ~rxClk;
always @(posedge txClk)
   if (txEn)
      txQ.push_back({txEr, txNib});
// pull-up when nobody drives
assign mdi = mdoe ? mdo : (phyOe ? phyBit : 1'h1);
always @(mdc)
begin
   if (mdc)
   begin
      mFrame <= {mFrame[62:0], mdi};
      bitNo <= (bitNo + 7'h1) & 7'h3f;
      if (bitNo == 7'h23)
         rd <= mFrame[0] & ~mdi;
      if (rd && bitNo >= 7'h2f)
      begin
         phyOe <= 1'h1;
         phyBit <= bitNo == 7'h2f ? 1'h0 : rdVal[7'h3f - bitNo];
      end
   end
   else if (bitNo == 7'h0)
      phyOe <= 1'h0;
end
task automatic rxSend(input logic dv, input logic [3:0] d, input logic er);
begin
   @(negedge rxClk);
   rxDv <= dv;
   rxNib <= dv ? d : ~rxNib;
   rxEr <= er;
end
endtask
endmodule // mpi_phy_model
`default_nettype wire

// ### tb_mii_mac_pin_interface.sv
// testbench for the mii pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_mii_mac_pin_interface;
logic ref_clk = 1'h0, rst_n = 1'h0, serialMode = 1'h0, fullDuplex = 1'h0;
logic txValid = 1'h0, txLast = 1'h0, txErr = 1'h0, mgmtStart = 1'h0, mgmtWrite = 1'h0;
logic collision_in = 1'h0, carrier_sense_in = 1'h0;
logic [3:0] txData = 4'h0;
logic [4:0] mgmtPhyAddr = 5'h0, mgmtRegAddr = 5'h0;
logic [15:0] mgmtWrData = 16'h0, rdVal = 16'h0;
wire txReady, rxValid, rxFrameEnd, rxFrameErr, collisionSeen, mediumBusy, mgmtBusy, mgmtDone;
wire tx_clock_in, tx_enable_out, tx_data_bit0, tx_error_out, rx_clock_in, rx_data_valid_in;
wire rx_data_bit0, rx_error_in, mgmt_clock_out, mgmt_data_in, mgmt_data_out, mgmt_data_oe;
wire [2:0] tx_data_upper, rx_data_upper;
wire [3:0] rxData, rxNibPins;
assign {rx_data_upper, rx_data_bit0} = rxNibPins;
wire [15:0] mgmtRdData;
int err_count = 0, n_compared = 0, cyc = 0;
logic [3:0] rxQ[$];
mpi_mac_pins dut (.*);
mpi_phy_model phy (.txClk(tx_clock_in), .rxClk(rx_clock_in), .txEn(tx_enable_out),
   .txNib({tx_data_upper, tx_data_bit0}), .txEr(tx_error_out), .rxDv(rx_data_valid_in),
   .rxNib(rxNibPins), .rxEr(rx_error_in), .mdc(mgmt_clock_out),
   .mdo(mgmt_data_out), .mdoe(mgmt_data_oe), .mdi(mgmt_data_in), .rdVal(rdVal));
always #5 ref_clk = ~ref_clk;
always @(posedge ref_clk)
begin
   if (rxValid === 1'h1)
      rxQ.push_back(rxData);
   cyc++;
   if (cyc == 40000)
   begin
      err_count++;
      stop_test();
   end
end
task automatic stop_test();
begin
   $display("compared %0d mismatches %0d", n_compared, err_count);
   if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
   else
      $display("MISMATCHES SEEN");
   $finish;
end
endtask
task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
begin
   n_compared++;
   if (got !== exp)
   begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
   end
end
endtask
task automatic txFrame(input int n);
int i, b, k;
logic [4:0] exp[$];
begin
   phy.txQ = {};
   for (i = 0; i < n; i++)
   begin
      txData = 4'($urandom);
      txErr = 1'($urandom);
      txLast = i == n - 1;
      txValid = 1'h1;
      k = 0;
      while (txReady !== 1'h1 && ++k < 500) @(posedge ref_clk) #1;
      @(posedge ref_clk) #1;
      if (serialMode)
         for (b = 0; b < 4; b++)
            exp.push_back({4'h0, txData[b]});
      else
         exp.push_back({txErr, txData});
   end
   txValid = 1'h0;
   k = 0;
   while (tx_enable_out !== 1'h0 && ++k < 2000) @(posedge ref_clk) #1;
   check("txLen", exp.size(), phy.txQ.size());
   foreach (exp[j]) check("txNib", exp[j], phy.txQ[j]);
end
endtask
task automatic rxFrame(input int n, input int errAt);
int i, b, k;
logic [3:0] d;
logic [3:0] exp[$];
begin
   rxQ = {};
   phy.rxSend(1'h0, 4'h0, 1'h1);
   for (i = 0; i < n; i++)
   begin
      d = 4'($urandom);
      exp.push_back(d);
      if (serialMode)
         for (b = 0; b < 4; b++)
            phy.rxSend(1'h1, {3'($urandom), d[b]}, 1'h0);
      else
         phy.rxSend(1'h1, d, i == errAt);
   end
   phy.rxSend(1'h0, 4'h0, 1'h1);
   k = 0;
   while (rxFrameEnd !== 1'h1 && ++k < 200) @(posedge ref_clk) #1;
   check("rxFrameErr", errAt < n, rxFrameErr);
   check("rxCount", n, rxQ.size());
   foreach (exp[j]) check("rxData", exp[j], rxQ[j]);
end
endtask
task automatic mgmt(input logic wr);
int k;
begin
   {mgmtPhyAddr, mgmtRegAddr, mgmtWrData, rdVal} = 42'({$urandom, $urandom});
   mgmtWrite = wr;
   mgmtStart = 1'h1;
   @(posedge ref_clk) #1;
   mgmtStart = 1'h0;
   k = 0;
   while (mgmtDone !== 1'h1 && ++k < 4000) @(posedge ref_clk) #1;
   check("mgmtHead", {32'hffffffff, 2'h1, wr ? 2'h1 : 2'h2, mgmtPhyAddr, mgmtRegAddr}, phy.mFrame[63:18]);
   if (wr)
      check("mgmtWr", {2'h2, mgmtWrData}, phy.mFrame[17:0]);
   else
      check("mgmtRd", rdVal, mgmtRdData);
end
endtask
initial
begin
   void'($urandom(32'hff6b197b));
   repeat (12) @(posedge ref_clk);
   #1 rst_n = 1'h1;
   for (int m = 0; m < 2; m++)
   begin
      serialMode = 1'(m);
      txFrame(1);
      for (int i = 0; i < 3; i++)
      begin
         txFrame(1 + $urandom % 6);
         rxFrame(1 + $urandom % 6, m ? 8 : $urandom % 8);
      end
   end
   collision_in = 1'h1;
   carrier_sense_in = 1'h1;
   repeat (5) @(posedge ref_clk) #1;
   check("collisionSeen", 1'h1, collisionSeen);
   check("mediumBusy", 1'h1, mediumBusy);
   fullDuplex = 1'h1;
   carrier_sense_in = 1'h0;
   repeat (5) @(posedge ref_clk) #1;
   check("collisionSeen", 1'h0, collisionSeen);
   check("mediumBusy", 1'h0, mediumBusy);
   mgmt(1'h1);
   mgmt(1'h0);
   stop_test();
end
endmodule // tb_mii_mac_pin_interface
`default_nettype wire
